// ==== design/twelve_bit_accum_datapath.sv ====
// accumulator, multiplier-quotient register, scratch pad and instruction sequencer
`timescale 1ns/1ps
// Behaviour
// RQ1: store writes the accumulator in parallel into the addressed scratch pad word.
// RQ2: scratch pad write enable low during store; read mode high during add.
// RQ3: swap exchanges accumulator and register by twelve crossed right shifts.
// RQ4: logical right shift: acc lsb into register msb, zero into acc msb.
// RQ5: arithmetic right shift keeps the accumulator sign bit.
// RQ6: left shift moves acc and register upper four bits left, register msb into acc.
// RQ7: accumulator left shift loads a+a with register msb as carry in.
// RQ8: add loads accumulator plus scratch pad word with zero carry in.
// RQ9: alu carry out is kept; chained add uses it as carry in.
// RQ10: subtract uses a-b-1 with carry in one, loads the difference.
// RQ11: chained subtract applies the stored carry out as borrow at carry in.
// RQ12: unsigned multiply clears acc, leaves 24-bit product in acc and register.
// RQ13: a multiply add with carry sets overflow; it shifts into acc msb.
// RQ14: parallel load mode is a low-level signal; results load in one pulse.
// RQ15: one advance pulse to the instruction counter ends every instruction.
// RQ16: multiply steps with register lsb zero skip the add and only shift.
// RQ17: multiply runs exactly twelve add-shift steps.
// RQ18: a sequencer counts exactly twelve serial pulses, then returns to idle.
// RQ19: instruction codes are our own encoding.
module twelve_bit_accum_datapath (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic instr_valid,
   input accum_pkg::instr_t instr,
   input wire logic load_valid,
   input accum_pkg::reg_pair_t load_word,
   output accum_pkg::reg_pair_t regs,
   output logic carry_flag,
   output logic overflow,
   output logic busy,
   output logic advance,
   output logic spm_write_n,
   output logic spm_read_mode,
   output logic acc_parallel_n,
   output logic alu_carry_in
);
   import accum_pkg::*;

   typedef enum {
      st_idle,
      st_exec,
      st_shift,
      st_mpy_clear,
      st_mpy_add,
      st_mpy_shift,
      st_advance
   } state_t;

   state_t state;
   state_t next_state;
   opcode_t op;
   opcode_t next_op;
   logic [7:0] addr;
   logic [3:0] count;
   logic [11:0] acc;
   logic [11:0] multiplier_quotient_register;
   logic [11:0] spm [0:SPM_DEPTH-1];
   logic [11:0] spm_word;
   alu_req_t alu_req;
   logic [11:0] alu_f;
   logic alu_cout;

   // true for the ops that load the alu result in parallel
   function automatic logic is_parallel_op(input opcode_t o);
      case (o)
         op_left_shift_pair, op_add, op_add_with_carry, op_subtract, op_subtract_with_borrow: is_parallel_op = 1'b1;
         default: is_parallel_op = 1'b0;
      endcase
   endfunction : is_parallel_op

   // true for the ops that read the scratch pad onto alu input b
   function automatic logic is_read_op(input opcode_t o);
      case (o)
         op_add, op_add_with_carry, op_subtract, op_subtract_with_borrow: is_read_op = 1'b1;
         default: is_read_op = 1'b0;
      endcase
   endfunction : is_read_op

   assign spm_word = spm[addr];

   // alu setup follows the op in execution; multiply always adds with zero carry
   always_comb begin
      alu_req.a = acc;
      alu_req.b = spm_word;
      alu_req.mode = alu_pass_b;
      alu_req.cin = 1'b0;
      if (state == st_mpy_add) begin
         alu_req.mode = alu_add; // RQ13
         alu_req.cin = 1'b0;
      end else begin
         case (op)
            op_left_shift_pair: begin
               alu_req.mode = alu_double; // RQ7
               alu_req.cin = multiplier_quotient_register[11]; // RQ7
            end
            op_add: begin
               alu_req.mode = alu_add; // RQ8
               alu_req.cin = 1'b0; // RQ8
            end
            op_add_with_carry: begin
               alu_req.mode = alu_add;
               alu_req.cin = carry_flag; // RQ9
            end
            op_subtract: begin
               alu_req.mode = alu_sub; // RQ10
               alu_req.cin = 1'b1; // RQ10
            end
            op_subtract_with_borrow: begin
               alu_req.mode = alu_sub;
               alu_req.cin = carry_flag; // RQ11
            end
            default: begin
               alu_req.mode = alu_pass_b;
               alu_req.cin = 1'b0;
            end
         endcase
      end
   end

   alu_unit u_alu (
      .req(alu_req),
      .f(alu_f),
      .carry_out(alu_cout)
   );

   // an instruction is only taken in idle; a load in the same cycle is ignored
   always_comb begin
      next_op = op;
      next_state = state;
      case (state)
         st_idle: begin
            if (instr_valid) begin
               next_op = instr.opcode;
               case (instr.opcode)
                  op_swap_registers: next_state = st_shift;
                  op_unsigned_multiply: next_state = st_mpy_clear;
                  default: next_state = st_exec; // RQ19
               endcase
            end
         end
         st_exec: next_state = st_advance;
         st_shift: begin
            if (count == SHIFT_PULSES - 4'h1) begin
               next_state = st_advance; // RQ18
            end
         end
         st_mpy_clear: next_state = st_mpy_add;
         st_mpy_add: next_state = st_mpy_shift;
         st_mpy_shift: begin
            if (count == MPY_STEPS - 4'h1) begin
               next_state = st_advance; // RQ17
            end else begin
               next_state = st_mpy_add;
            end
         end
         st_advance: next_state = st_idle;
         default: next_state = st_idle;
      endcase
   end

   // sequencer state, captured op and scratch pad address
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= st_idle;
         op <= op_store_accumulator;
         addr <= 8'h00;
      end else begin
         state <= next_state;
         op <= next_op;
         if (state == st_idle && instr_valid) begin
            addr <= instr.addr;
         end
      end
   end

   // pulse counter shared by swap and multiply, cleared on every return to idle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count <= COUNT_RESET;
      end else if (state == st_shift || state == st_mpy_shift) begin
         count <= count + 4'h1; // RQ18
      end else if (state == st_idle) begin
         count <= COUNT_RESET;
      end
   end

   // control strobes are registered from the next state so they line up with the action
   always_ff @(posedge core_clk) begin
      if (rst) begin
         spm_write_n <= 1'b1;
         spm_read_mode <= 1'b0;
         acc_parallel_n <= 1'b1;
         busy <= 1'b0;
         advance <= 1'b0;
      end else begin
         spm_write_n <= !(next_state == st_exec && next_op == op_store_accumulator); // RQ2
         spm_read_mode <= (next_state == st_exec && is_read_op(next_op)) || next_state == st_mpy_add; // RQ2
         acc_parallel_n <= !((next_state == st_exec && is_parallel_op(next_op)) || next_state == st_mpy_add); // RQ14
         busy <= next_state != st_idle;
         advance <= next_state == st_advance; // RQ15
      end
   end

   // mirror of the carry input the alu sees, for observation
   always_ff @(posedge core_clk) begin
      if (rst) begin
         alu_carry_in <= 1'b0;
      end else begin
         alu_carry_in <= alu_req.cin;
      end
   end

   // scratch pad write; no reset, contents are undefined until stored
   always_ff @(posedge core_clk) begin
      if (state == st_exec && !spm_write_n) begin
         spm[addr] <= acc; // RQ1
      end
   end

   // accumulator and multiplier-quotient register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc <= WORD_RESET;
         multiplier_quotient_register <= WORD_RESET;
      end else begin
         case (state)
            st_idle: begin
               if (!instr_valid && load_valid) begin
                  acc <= load_word.acc;
                  multiplier_quotient_register <= load_word.multiplier_quotient_register;
               end
            end
            st_exec: begin
               case (op)
                  op_logical_right_shift: begin
                     acc <= {1'b0, acc[11:1]}; // RQ4
                     multiplier_quotient_register <= {acc[0], multiplier_quotient_register[11:1]}; // RQ4
                  end
                  op_arithmetic_right_shift: begin
                     acc <= {acc[11], acc[11:1]}; // RQ5
                     multiplier_quotient_register <= {acc[0], multiplier_quotient_register[11:1]}; // RQ5
                  end
                  op_left_shift_pair: begin
                     acc <= alu_f; // RQ6
                     multiplier_quotient_register <= {multiplier_quotient_register[10:8], 1'b0,
                        multiplier_quotient_register[7:0]}; // RQ6
                  end
                  op_add, op_add_with_carry, op_subtract, op_subtract_with_borrow: begin
                     if (!acc_parallel_n) begin
                        acc <= alu_f; // RQ14
                     end
                  end
                  default: begin
                     acc <= acc;
                  end
               endcase
            end
            st_shift: begin
               acc <= {multiplier_quotient_register[0], acc[11:1]}; // RQ3
               multiplier_quotient_register <= {acc[0], multiplier_quotient_register[11:1]}; // RQ3
            end
            st_mpy_clear: acc <= WORD_RESET; // RQ12
            st_mpy_add: begin
               if (multiplier_quotient_register[0]) begin
                  acc <= alu_f; // RQ16
               end
            end
            st_mpy_shift: begin
               acc <= {overflow, acc[11:1]}; // RQ13
               multiplier_quotient_register <= {acc[0], multiplier_quotient_register[11:1]}; // RQ12
            end
            default: begin
               acc <= acc;
            end
         endcase
      end
   end

   // stored carry: written by the four add and subtract ops only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         carry_flag <= FLAG_RESET;
      end else if (state == st_exec && is_read_op(op)) begin
         carry_flag <= alu_cout; // RQ9
      end
   end

   // overflow is cleared before the first multiply add and reloaded on each add, zero when the add is skipped
   always_ff @(posedge core_clk) begin
      if (rst) begin
         overflow <= FLAG_RESET;
      end else if (state == st_mpy_clear) begin
         overflow <= 1'b0;
      end else if (state == st_mpy_add) begin
         overflow <= multiplier_quotient_register[0] & alu_cout; // RQ13
      end
   end

   // register outputs from a second flop stage, one cycle behind acc and the register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         regs <= {WORD_RESET, WORD_RESET};
      end else begin
         regs <= {next_acc_view(), next_quotient_view()};
      end
   end

   function automatic logic [11:0] next_acc_view();
      next_acc_view = acc;
   endfunction : next_acc_view

   function automatic logic [11:0] next_quotient_view();
      next_quotient_view = multiplier_quotient_register;
   endfunction : next_quotient_view

endmodule : twelve_bit_accum_datapath

// ==== design/accum_pkg.sv ====
// constants, encodings and carrier types shared by the accumulator datapath
package accum_pkg;

   localparam int WORD_W = 12;
   localparam int SPM_DEPTH = 256;
   localparam int ADDR_W = 8;
   localparam logic [3:0] SHIFT_PULSES = 4'hC;
   localparam logic [3:0] MPY_STEPS = 4'hC;
   localparam logic [3:0] COUNT_RESET = 4'h0;
   localparam logic [11:0] WORD_RESET = 12'h000;
   localparam logic FLAG_RESET = 1'b0;

   // implementation-defined instruction codes
   typedef enum logic [3:0] {
      op_store_accumulator = 4'h0,
      op_swap_registers = 4'h1,
      op_logical_right_shift = 4'h2,
      op_arithmetic_right_shift = 4'h3,
      op_left_shift_pair = 4'h4,
      op_add = 4'h5,
      op_add_with_carry = 4'h6,
      op_subtract = 4'h7,
      op_subtract_with_borrow = 4'h8,
      op_unsigned_multiply = 4'h9
   } opcode_t;

   typedef enum logic [1:0] {
      alu_add,
      alu_sub,
      alu_double,
      alu_pass_b
   } alu_mode_t;

   typedef struct packed {
      opcode_t opcode;
      logic [7:0] addr;
   } instr_t;

   typedef struct packed {
      logic [11:0] acc;
      logic [11:0] multiplier_quotient_register;
   } reg_pair_t;

   typedef struct packed {
      alu_mode_t mode;
      logic [11:0] a;
      logic [11:0] b;
      logic cin;
   } alu_req_t;

endpackage : accum_pkg

// ==== design/alu_unit.sv ====
// twelve-bit alu: a+b, a-b-1 and a+a, each with carry in, and pass-b, which ignores carry in
`timescale 1ns/1ps
module alu_unit (
   input accum_pkg::alu_req_t req,
   output logic [11:0] f,
   output logic carry_out
);
   import accum_pkg::*;

   logic [12:0] sum;
   logic [11:0] b_eff;

   // subtract adds the complement, so carry out high means no borrow
   always_comb begin
      case (req.mode)
         alu_add: b_eff = req.b;
         alu_sub: b_eff = ~req.b;
         alu_double: b_eff = req.a;
         default: b_eff = req.b;
      endcase
      sum = {1'b0, req.a} + {1'b0, b_eff} + {12'h000, req.cin};
      if (req.mode == alu_pass_b) begin
         f = req.b;
         carry_out = 1'b0;
      end else begin
         f = sum[11:0];
         carry_out = sum[12];
      end
   end

endmodule : alu_unit

// ==== design/_unused_placeholder_removed.sv ====
// intentionally empty design unit list terminator
`timescale 1ns/1ps

// ==== tb/accum_checker_assertions.sv ====
// concurrent checks on the accumulator datapath ports
`timescale 1ns/1ps
module accum_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic busy,
   input wire logic advance,
   input wire logic carry_flag,
   input wire logic spm_write_n,
   input wire logic spm_read_mode,
   input wire logic acc_parallel_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_adv_pulse; advance |=> !advance; endproperty
   a_adv_pulse: assert property (p_adv_pulse) else $error("advance longer than one cycle");
   property p_adv_busy; advance |-> busy; endproperty
   a_adv_busy: assert property (p_adv_busy) else $error("advance outside busy");
   property p_take; instr_valid && !busy |=> busy; endproperty
   a_take: assert property (p_take) else $error("offered instruction not taken");
   property p_bounded; $rose(busy) |-> ##[1:25] advance; endproperty
   a_bounded: assert property (p_bounded) else $error("instruction overran 25 cycles");
   property p_store; !spm_write_n |=> advance && spm_write_n; endproperty
   a_store: assert property (p_store) else $error("store strobe not one cycle before advance");
   property p_write_excl; !spm_write_n |-> !spm_read_mode && acc_parallel_n; endproperty
   a_write_excl: assert property (p_write_excl) else $error("write mixed with read or load");
   property p_read_load; spm_read_mode |-> !acc_parallel_n && busy; endproperty
   a_read_load: assert property (p_read_load) else $error("read without parallel load");
   property p_load_busy; !acc_parallel_n |-> busy; endproperty
   a_load_busy: assert property (p_load_busy) else $error("parallel load while idle");
   property p_carry_hold; !spm_read_mode |=> $stable(carry_flag); endproperty
   a_carry_hold: assert property (p_carry_hold) else $error("carry changed without alu read");
endmodule : accum_checker

// ==== tb/instr_source.sv ====
// instruction counter model feeding one bench-supplied instruction at a time
`timescale 1ns/1ps
module instr_source (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input accum_pkg::instr_t word,
   input wire logic busy,
   input wire logic advance,
   output logic instr_valid,
   output accum_pkg::instr_t instr,
   output logic [7:0] count
);
   import accum_pkg::*;
   // hold the word until busy shows it taken; afterwards the lines carry junk
   always_ff @(posedge core_clk) begin
      if (rst) begin
         instr_valid <= 1'b0;
         instr <= '0;
      end else if (start) begin
         instr_valid <= 1'b1;
         instr <= word;
      end else if (busy && instr_valid) begin
         instr_valid <= 1'b0;
         instr <= ~instr;
      end
   end
   // instruction counter steps on each advance pulse
   always_ff @(posedge core_clk) begin
      if (rst) count <= 8'h00;
      else if (advance) count <= count + 8'h01;
   end
endmodule : instr_source

// ==== tb/testbench.sv ====
// self-checking bench for the accumulator datapath
`timescale 1ns/1ps
module testbench;
   import accum_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic load_valid = 1'b0;
   logic start = 1'b0;
   reg_pair_t load_word = '0;
   instr_t word = '0;
   logic instr_valid;
   instr_t instr;
   logic [7:0] count;
   reg_pair_t regs;
   logic carry_flag, overflow, busy, advance, spm_write_n, spm_read_mode, acc_parallel_n, alu_carry_in;
   int num_errors = 0;
   int checks_done = 0;
   int n_instr = 0;

   twelve_bit_accum_datapath twelve_bit_accum_datapath_i (.core_clk(core_clk), .rst(rst),
      .instr_valid(instr_valid), .instr(instr), .load_valid(load_valid), .load_word(load_word),
      .regs(regs), .carry_flag(carry_flag), .overflow(overflow), .busy(busy), .advance(advance),
      .spm_write_n(spm_write_n), .spm_read_mode(spm_read_mode), .acc_parallel_n(acc_parallel_n),
      .alu_carry_in(alu_carry_in));
   instr_source instr_source_i (.core_clk(core_clk), .rst(rst), .start(start), .word(word),
      .busy(busy), .advance(advance), .instr_valid(instr_valid), .instr(instr), .count(count));

   initial forever #12.5 core_clk = ~core_clk;

   task automatic check(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize

   // preload goes through the test path; regs lags one cycle, hence two edges
   task automatic preload(input logic [11:0] a, input logic [11:0] m);
      @(negedge core_clk) load_valid = 1'b1;
      load_word = '{acc: a, multiplier_quotient_register: m};
      @(negedge core_clk) load_valid = 1'b0;
      @(negedge core_clk);
   endtask : preload

   // issue one instruction, count busy cycles before advance, bounded wait
   task automatic run(input opcode_t op, input logic [7:0] a, input int lat);
      int n, w;
      n = 0;
      w = 0;
      @(negedge core_clk) start = 1'b1;
      word = '{opcode: op, addr: a};
      @(negedge core_clk) start = 1'b0;
      while (advance !== 1'b1) begin
         if (busy === 1'b1) n++;
         @(negedge core_clk) w++;
         if (w > 60) begin
            num_errors++;
            $display("MISMATCH at %0t: no advance", $time);
            summarize();
         end
      end
      n_instr++;
      check(n == lat, "busy length before advance");
      repeat (2) @(negedge core_clk);
   endtask : run

   task automatic expect_regs(input logic [11:0] a, input logic [11:0] m, input string msg);
      check(regs.acc === a && regs.multiplier_quotient_register === m, msg);
   endtask : expect_regs

   task automatic test_shifts();
      preload(12'h800, 12'h123);
      run(op_logical_right_shift, 8'h00, 1);
      expect_regs(12'h400, 12'h091, "logical right shift");
      preload(12'h801, 12'h123);
      run(op_arithmetic_right_shift, 8'h00, 1);
      expect_regs(12'hC00, 12'h891, "arithmetic right shift");
      preload(12'h801, 12'h9F5);
      run(op_left_shift_pair, 8'h00, 1);
      expect_regs(12'h003, 12'h2F5, "left shift pair");
      $display("test shifts done");
   endtask : test_shifts

   task automatic test_swap();
      preload(12'hABC, 12'h123);
      run(op_swap_registers, 8'h00, 12);
      expect_regs(12'h123, 12'hABC, "swap");
      $display("test swap done");
   endtask : test_swap

   task automatic test_store_add();
      preload(12'hFFF, 12'h000);
      run(op_store_accumulator, 8'h10, 1);
      preload(12'h005, 12'h000);
      run(op_store_accumulator, 8'h20, 1);
      preload(12'h001, 12'h000);
      run(op_add, 8'h10, 1);
      expect_regs(12'h000, 12'h000, "add sum");
      check(carry_flag === 1'b1, "add carry out");
      check(alu_carry_in === 1'b0, "add carry in zero");
      preload(12'h001, 12'h000);
      run(op_add_with_carry, 8'h20, 1);
      expect_regs(12'h007, 12'h000, "chained add");
      check(carry_flag === 1'b0, "chained add carry");
      $display("test store add done");
   endtask : test_store_add

   task automatic test_subtract();
      preload(12'h005, 12'h000);
      run(op_subtract, 8'h20, 1);
      expect_regs(12'h000, 12'h000, "subtract");
      check(carry_flag === 1'b1, "subtract no borrow");
      check(alu_carry_in === 1'b1, "subtract carry in forced one");
      preload(12'h003, 12'h000);
      run(op_subtract_with_borrow, 8'h20, 1);
      expect_regs(12'hFFE, 12'h000, "chained subtract no borrow in");
      check(carry_flag === 1'b0, "subtract borrow out");
      preload(12'h010, 12'h000);
      run(op_subtract_with_borrow, 8'h20, 1);
      expect_regs(12'h00A, 12'h000, "chained subtract with borrow");
      $display("test subtract done");
   endtask : test_subtract

   task automatic test_multiply();
      preload(12'h555, 12'hFFF);
      run(op_unsigned_multiply, 8'h10, 25);
      expect_regs(12'hFFE, 12'h001, "full product");
      check(overflow === 1'b1, "overflow on last add");
      preload(12'h7FF, 12'h002);
      run(op_unsigned_multiply, 8'h20, 25);
      expect_regs(12'h000, 12'h00A, "product with skipped adds");
      check(overflow === 1'b0, "overflow after skipped add");
      $display("test multiply done");
   endtask : test_multiply

   task automatic test_unknown();
      preload(12'h3C3, 12'h5A5);
      run(opcode_t'(4'hF), 8'h00, 1);
      expect_regs(12'h3C3, 12'h5A5, "unused code leaves registers");
      check(count === n_instr[7:0], "one advance per instruction");
      $display("test unknown done");
   endtask : test_unknown

   // reset in the middle of a multiply: all returns to idle and the next instruction runs at once
   task automatic test_reset();
      preload(12'h000, 12'hFFF);
      @(negedge core_clk) start = 1'b1;
      word = '{opcode: op_unsigned_multiply, addr: 8'h10};
      @(negedge core_clk) start = 1'b0;
      repeat (6) @(negedge core_clk);
      check(busy === 1'b1 && overflow === 1'b1, "multiply under way");
      rst = 1'b1;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      check(regs === '0 && carry_flag === 1'b0 && overflow === 1'b0, "state after reset");
      check(busy === 1'b0 && advance === 1'b0, "sequencer after reset");
      check(spm_write_n === 1'b1 && spm_read_mode === 1'b0 && acc_parallel_n === 1'b1, "strobes after reset");
      check(count === 8'h00, "counter after reset");
      preload(12'h801, 12'h123);
      run(op_arithmetic_right_shift, 8'h00, 1);
      expect_regs(12'hC00, 12'h891, "first instruction after reset");
      check(count === 8'h01, "one advance after reset");
      $display("test reset done");
   endtask : test_reset

   initial begin
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      test_shifts();
      test_swap();
      test_store_add();
      test_subtract();
      test_multiply();
      test_unknown();
      test_reset();
      summarize();
   end
endmodule : testbench

bind twelve_bit_accum_datapath accum_checker accum_checker_i (.core_clk(core_clk), .rst(rst),
   .instr_valid(instr_valid), .busy(busy), .advance(advance), .carry_flag(carry_flag),
   .spm_write_n(spm_write_n), .spm_read_mode(spm_read_mode), .acc_parallel_n(acc_parallel_n));
